// file: logic/rsi_pkg.sv
// Constants for the regulator status and interrupt mask register slice.
// Assumes an I2C target engine decodes frames into byte register accesses.
//
// Summary of operation
// - Status bit 7 reports second linear regulator enabled; resets to 0.
// - Status bit 6 shows live second linear regulator output invalid state.
// - Status bit 4 shows live second linear regulator current limit state.
// - Status bit 3 reports first linear regulator enabled; resets to 0.
// - Status bit 2 shows live first linear regulator output invalid state.
// - Status bit 0 shows live first linear regulator current limit state.
// - Top mask one at 0x20 holds power-good, clock, thermal, measure masks.
// - Top mask one bit 7 blocks power-good interrupt; resets to 1.
// - Mask bits gate interrupt generation only, never the status bits.
// - Top mask one bit 4 blocks external clock interrupt; resets to 1.
// - Top mask one bit 2 blocks thermal warning interrupt; resets to 0.
// - Top mask one bit 0 blocks measurement ready interrupt; resets to 0.
// - Top mask two bit 0 at 0x21 blocks register-reset interrupt; resets 1.
// - Register-reset mask loads from one-time storage; host writes ignored.
// - Buck mask at 0x22: bits 7,6,4 second switcher, 3,2,0 first.
// - Regulator power-good has separate masks for going invalid and going valid.
// - Flags latch on event, clear when host writes 1 to their bit.
package rsi_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] TOP_FLAG_ONE_ADDR = 8'h18;
   localparam logic [7:0] TOP_FLAG_TWO_ADDR = 8'h19;
   localparam logic [7:0] BUCK_FLAG_ADDR = 8'h1a;
   localparam logic [7:0] LINREG_FLAG_ADDR = 8'h1b;
   localparam logic [7:0] LINREG_STATUS_ADDR = 8'h1f;
   localparam logic [7:0] TOP_MASK_ONE_ADDR = 8'h20;
   localparam logic [7:0] TOP_MASK_TWO_ADDR = 8'h21;
   localparam logic [7:0] BUCK_MASK_ADDR = 8'h22;
   localparam logic [7:0] LINREG_MASK_ADDR = 8'h23;

   // ----------------------------------------------------------------
   // Reset values and writable bits
   // ----------------------------------------------------------------
   localparam logic [7:0] TOP_MASK_ONE_RST = 8'h90;
   localparam logic [7:0] TOP_MASK_ONE_WMASK = 8'h95;
   localparam logic [7:0] REG_MASK_RST = 8'hcc;
   localparam logic [7:0] REG_MASK_WMASK = 8'hdd;
   localparam logic RESET_MASK_RST = 1'b1;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PGOOD_BIT = 7;
   localparam int SYNC_CLK_BIT = 4;
   localparam int THERMAL_BIT = 2;
   localparam int MEAS_BIT = 0;
   localparam int RESET_BIT = 0;
   // Per regulator, offset from 0 (first) or 4 (second) within a byte
   localparam int PGF_OFS = 3;
   localparam int PGR_OFS = 2;
   localparam int PG_OFS = 2;
   localparam int EN_OFS = 3;
   localparam int ILIM_OFS = 0;
   localparam int HALF_OFS = 4;

   // ----------------------------------------------------------------
   // Synchroniser vector layout; regulators 0..3 are switcher a, b,
   // linear a, linear b
   // ----------------------------------------------------------------
   localparam int NREG = 4;
   localparam int S_PGOOD = 0;
   localparam int S_SYNC = 1;
   localparam int S_THERM = 2;
   localparam int S_MEAS = 3;
   localparam int S_RESET = 4;
   localparam int S_OTP = 5;
   localparam int S_EN = 6;
   localparam int S_INV = S_EN + NREG;
   localparam int S_ILIM = S_INV + NREG;
   localparam int SYNC_W = S_ILIM + NREG;

   // Cycles after reset release until the synchronised one-time value is valid
   localparam logic [1:0] OTP_LOAD_CYCLE = 2'h2;
endpackage : rsi_pkg

// file: logic/rsi_regulator_irq.sv
// Regulator status, interrupt masks, latched flags and combined request.
// Assumes raw event levels arrive asynchronously from the analog side and
// an I2C target engine presents one-cycle byte read and write strobes.
module rsi_regulator_irq
   import rsi_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   // Register port from the I2C target engine
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Raw conditions, asynchronous
   input wire logic power_good_pin_state,
   input wire logic sync_clk_invalid,
   input wire logic thermal_warning_state,
   input wire logic current_measure_ready,
   input wire logic register_reset_event,
   input wire logic otp_reset_irq_block,
   input wire logic switcher_a_enabled,
   input wire logic switcher_a_output_invalid,
   input wire logic switcher_a_current_limit,
   input wire logic switcher_b_enabled,
   input wire logic switcher_b_output_invalid,
   input wire logic switcher_b_current_limit,
   input wire logic linreg_a_enabled_flag,
   input wire logic linreg_a_output_invalid_raw,
   input wire logic linreg_a_current_limit_raw,
   input wire logic linreg_b_enabled_flag,
   input wire logic linreg_b_output_invalid_raw,
   input wire logic linreg_b_current_limit_raw,
   // Combined interrupt request, active high
   output logic irq
);
   import rsi_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] meta_reg;
   logic [SYNC_W-1:0] sync_reg;
   logic [SYNC_W-1:0] prev_reg;

   // Bit order must match the S_ positions of the package
   assign raw_in = {
      linreg_b_current_limit_raw, linreg_a_current_limit_raw,
      switcher_b_current_limit, switcher_a_current_limit,
      linreg_b_output_invalid_raw, linreg_a_output_invalid_raw,
      switcher_b_output_invalid, switcher_a_output_invalid,
      linreg_b_enabled_flag, linreg_a_enabled_flag,
      switcher_b_enabled, switcher_a_enabled,
      otp_reset_irq_block, register_reset_event, current_measure_ready,
      thermal_warning_state, sync_clk_invalid, power_good_pin_state};

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end
      else
      begin
         meta_reg <= raw_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Edge history: second stage against third; the first stage never feeds logic
   wire [SYNC_W-1:0] rise_w = sync_reg & ~prev_reg;
   wire [SYNC_W-1:0] fall_w = ~sync_reg & prev_reg;

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   wire wr_top1_mask = reg_wr && (reg_addr == TOP_MASK_ONE_ADDR);
   wire wr_buck_mask = reg_wr && (reg_addr == BUCK_MASK_ADDR);
   wire wr_lin_mask = reg_wr && (reg_addr == LINREG_MASK_ADDR);
   wire wr_top1_flag = reg_wr && (reg_addr == TOP_FLAG_ONE_ADDR);
   wire wr_top2_flag = reg_wr && (reg_addr == TOP_FLAG_TWO_ADDR);
   wire wr_buck_flag = reg_wr && (reg_addr == BUCK_FLAG_ADDR);
   wire wr_lin_flag = reg_wr && (reg_addr == LINREG_FLAG_ADDR);

   // ----------------------------------------------------------------
   // Mask registers
   // ----------------------------------------------------------------
   logic [7:0] top_interrupt_mask_one_reg;
   logic [7:0] buck_interrupt_mask_reg;
   logic [7:0] linreg_interrupt_mask_reg;
   logic reset_irq_block_reg;
   logic [1:0] otp_cnt_reg;

   // Reserved bits never store, so they read zero
   wire [7:0] top1_mask_next =
      reg_wdata & TOP_MASK_ONE_WMASK;
   wire [7:0] buck_mask_next = reg_wdata & REG_MASK_WMASK;
   wire [7:0] lin_mask_next = reg_wdata & REG_MASK_WMASK;

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         top_interrupt_mask_one_reg <= TOP_MASK_ONE_RST;
         buck_interrupt_mask_reg <= REG_MASK_RST;
         linreg_interrupt_mask_reg <= REG_MASK_RST;
      end
      else
      begin
         if (wr_top1_mask)
            top_interrupt_mask_one_reg <= top1_mask_next;
         if (wr_buck_mask)
            buck_interrupt_mask_reg <= buck_mask_next;
         if (wr_lin_mask)
            linreg_interrupt_mask_reg <= lin_mask_next;
      end
   end

   // Host writes are ignored: the value comes from one-time storage.
   // The synchroniser output holds the pin only after OTP_LOAD_CYCLE
   // edges, so the capture waits for the edge after that.
   wire otp_load = (otp_cnt_reg == OTP_LOAD_CYCLE);
   wire otp_done = (otp_cnt_reg == OTP_LOAD_CYCLE + 2'h1);
   wire [1:0] otp_cnt_next = otp_done ? otp_cnt_reg
      : otp_cnt_reg + 2'h1;
   wire reset_irq_block_next = otp_load ? sync_reg[S_OTP]
      : reset_irq_block_reg;

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         otp_cnt_reg <= '0;
         reset_irq_block_reg <= RESET_MASK_RST;
      end
      else
      begin
         otp_cnt_reg <= otp_cnt_next;
         reset_irq_block_reg <= reset_irq_block_next;
      end
   end

   wire power_good_irq_block = top_interrupt_mask_one_reg[PGOOD_BIT];
   wire sync_clk_irq_block = top_interrupt_mask_one_reg[SYNC_CLK_BIT];
   wire thermal_warning_irq_block = top_interrupt_mask_one_reg[THERMAL_BIT];
   wire current_measure_irq_block = top_interrupt_mask_one_reg[MEAS_BIT];

   // ----------------------------------------------------------------
   // Top level flags
   // ----------------------------------------------------------------
   logic power_good_irq_flag;
   logic sync_clk_irq_flag;
   logic thermal_warning_irq_flag;
   logic current_measure_done_flag;
   logic register_reset_irq_flag;

   // Set wins over a clear in the same cycle
   wire pg_set = (rise_w[S_PGOOD] | fall_w[S_PGOOD])
      & ~power_good_irq_block;
   wire sc_set = (rise_w[S_SYNC] | fall_w[S_SYNC])
      & ~sync_clk_irq_block;
   wire tw_set = rise_w[S_THERM] & ~thermal_warning_irq_block;
   wire cm_set = rise_w[S_MEAS] & ~current_measure_irq_block;
   wire rr_set = rise_w[S_RESET] & ~reset_irq_block_reg;

   // Write one to clear
   wire pg_clr = wr_top1_flag & reg_wdata[PGOOD_BIT];
   wire sc_clr = wr_top1_flag & reg_wdata[SYNC_CLK_BIT];
   wire tw_clr = wr_top1_flag & reg_wdata[THERMAL_BIT];
   wire cm_clr = wr_top1_flag & reg_wdata[MEAS_BIT];
   wire rr_clr = wr_top2_flag & reg_wdata[RESET_BIT];
   wire pwr_good_next = pg_set | (power_good_irq_flag & ~pg_clr);
   wire clk_flag_next = sc_set | (sync_clk_irq_flag & ~sc_clr);
   wire therm_flag_next = tw_set | (thermal_warning_irq_flag & ~tw_clr);
   wire meas_flag_next = cm_set | (current_measure_done_flag & ~cm_clr);
   wire rst_flag_next = rr_set | (register_reset_irq_flag & ~rr_clr);

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         power_good_irq_flag <= 1'b0;
         sync_clk_irq_flag <= 1'b0;
         thermal_warning_irq_flag <= 1'b0;
         current_measure_done_flag <= 1'b0;
         register_reset_irq_flag <= 1'b0;
      end
      else
      begin
         power_good_irq_flag <= pwr_good_next;
         sync_clk_irq_flag <= clk_flag_next;
         thermal_warning_irq_flag <= therm_flag_next;
         current_measure_done_flag <= meas_flag_next;
         register_reset_irq_flag <= rst_flag_next;
      end
   end

   // ----------------------------------------------------------------
   // Per regulator flags: 0,1 in buck bytes, 2,3 in linear bytes
   // ----------------------------------------------------------------
   logic [NREG-1:0] pg_flag_reg;
   logic [NREG-1:0] ilim_flag_reg;

   genvar g;
   generate
      for (g = 0; g < NREG; g++)
      begin : g_reg
         localparam int BASE = (g % 2) * HALF_OFS;
         wire [7:0] mask_w = (g < 2) ? buck_interrupt_mask_reg
            : linreg_interrupt_mask_reg;
         wire clr_w = (g < 2) ? wr_buck_flag : wr_lin_flag;
         // Two masks: one per direction of the validity change
         wire pg_evt = (rise_w[S_INV+g] & ~mask_w[BASE+PGF_OFS])
            | (fall_w[S_INV+g] & ~mask_w[BASE+PGR_OFS]);
         wire il_evt = rise_w[S_ILIM+g] & ~mask_w[BASE+ILIM_OFS];
         wire pg_clr_w = clr_w & reg_wdata[BASE+PG_OFS];
         wire il_clr_w = clr_w & reg_wdata[BASE+ILIM_OFS];
         always_ff @(posedge mclk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               pg_flag_reg[g] <= 1'b0;
               ilim_flag_reg[g] <= 1'b0;
            end
            else
            begin
               pg_flag_reg[g] <= pg_evt | (pg_flag_reg[g]
                  & ~pg_clr_w);
               ilim_flag_reg[g] <= il_evt | (ilim_flag_reg[g]
                  & ~il_clr_w);
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read path and request
   // ----------------------------------------------------------------
   // Status follows the synchronised raw level, untouched by masks
   wire [7:0] lin_status_w = {
      sync_reg[S_EN+3],
      sync_reg[S_INV+3],
      1'b0,
      sync_reg[S_ILIM+3],
      sync_reg[S_EN+2],
      sync_reg[S_INV+2],
      1'b0,
      sync_reg[S_ILIM+2]};
   wire [7:0] top1_flag_w = {power_good_irq_flag, 2'h0,
      sync_clk_irq_flag, 1'b0, thermal_warning_irq_flag, 1'b0,
      current_measure_done_flag};
   wire [7:0] buck_flag_w = {1'b0, pg_flag_reg[1], 1'b0,
      ilim_flag_reg[1], 1'b0, pg_flag_reg[0], 1'b0, ilim_flag_reg[0]};
   wire [7:0] lin_flag_w = {1'b0, pg_flag_reg[3], 1'b0,
      ilim_flag_reg[3], 1'b0, pg_flag_reg[2], 1'b0, ilim_flag_reg[2]};

   logic [7:0] rdata_next;
   always_comb
   begin
      unique case (reg_addr)
         LINREG_STATUS_ADDR: rdata_next = lin_status_w;
         TOP_MASK_ONE_ADDR: rdata_next = top_interrupt_mask_one_reg;
         TOP_MASK_TWO_ADDR: rdata_next = {7'h00, reset_irq_block_reg};
         BUCK_MASK_ADDR: rdata_next = buck_interrupt_mask_reg;
         LINREG_MASK_ADDR: rdata_next = linreg_interrupt_mask_reg;
         TOP_FLAG_ONE_ADDR: rdata_next = top1_flag_w;
         TOP_FLAG_TWO_ADDR: rdata_next = {7'h00, register_reset_irq_flag};
         BUCK_FLAG_ADDR: rdata_next = buck_flag_w;
         LINREG_FLAG_ADDR: rdata_next = lin_flag_w;
         default: rdata_next = 8'h00;
      endcase
   end

   // Registered so the request line cannot glitch while flags settle
   wire top_flags_any = (|top1_flag_w) | register_reset_irq_flag;
   wire reg_flags_any = (|pg_flag_reg) | (|ilim_flag_reg);
   wire irq_next = top_flags_any | reg_flags_any;

   // Held between reads so the target engine may fetch the byte late
   logic [7:0] reg_rdata_reg;
   logic irq_reg;
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reg_rdata_reg <= 8'h00;
         irq_reg <= 1'b0;
      end
      else
      begin
         if (reg_rd)
            reg_rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign reg_rdata = reg_rdata_reg;
   assign irq = irq_reg;
endmodule : rsi_regulator_irq

// file: tb/rsi_host_model.sv
// Host side of the register port, standing in for the I2C target engine.
// Assumes the shared mclk; requests change only on falling edges.
module rsi_host_model
(
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end

   // Idle address and data are inverted so a stale value never helps
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
endmodule : rsi_host_model

// file: tb/rsi_regulator_irq_chk.sv
// Port-level checks on register reads, mask writes and the request line.
// Assumes one mclk domain and async active-high sys_rst.
module rsi_irq_chk
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic otp_reset_irq_block,
   input wire logic linreg_a_enabled_flag,
   input wire logic linreg_a_output_invalid_raw,
   input wire logic linreg_a_current_limit_raw,
   input wire logic linreg_b_enabled_flag,
   input wire logic linreg_b_output_invalid_raw,
   input wire logic linreg_b_current_limit_raw,
   input wire logic irq
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   logic [2:0] up_cnt;
   logic [7:0] stat_raw;
   logic settled;
   assign stat_raw = {linreg_b_enabled_flag, linreg_b_output_invalid_raw,
      1'b0, linreg_b_current_limit_raw, linreg_a_enabled_flag,
      linreg_a_output_invalid_raw, 1'b0, linreg_a_current_limit_raw};
   assign settled = (up_cnt == 3'h7);
   // Synchronisers still hold reset values just after release
   always_ff @(posedge mclk or posedge sys_rst)
      if (sys_rst)
         up_cnt <= 3'h0;
      else if (!settled)
         up_cnt <= up_cnt + 3'h1;
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   chk_top1_rsvd: assert property (
      reg_rd && reg_addr == 8'h20 |=> (reg_rdata & 8'h6a) == 8'h00)
      else $error("mask one reserved bit reads set");
   chk_buck_rsvd: assert property (
      reg_rd && reg_addr == 8'h22 |=> (reg_rdata & 8'h22) == 8'h00)
      else $error("buck mask reserved bit reads set");
   chk_stat_rsvd: assert property (
      reg_rd && reg_addr == 8'h1f |=> (reg_rdata & 8'h22) == 8'h00)
      else $error("status reserved bit reads set");
   chk_stat_live: assert property (
      reg_rd && reg_addr == 8'h1f && settled && $stable(stat_raw) &&
      $past(stat_raw, 2) == stat_raw && $past(stat_raw, 3) == stat_raw
      |=> reg_rdata == $past(stat_raw)) else $error("status byte wrong");
   chk_mask_wr: assert property (
      reg_wr && !reg_rd && reg_addr == 8'h20 ##1 !reg_wr ##1
      !reg_wr && reg_rd && reg_addr == 8'h20
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'h95))
      else $error("mask one readback wrong");
   chk_otp_mask: assert property (
      reg_rd && !reg_wr && reg_addr == 8'h21 && settled
      |=> reg_rdata == {7'h00, $past(otp_reset_irq_block)})
      else $error("mask two does not follow stored value");
   chk_irq_hold: assert property (
      irq && !reg_wr && !$past(reg_wr) |=> irq)
      else $error("request dropped without a clear");
   chk_irq_fall: assert property (
      $fell(irq) |-> $past(reg_wr, 2) && $past(reg_addr, 2) >= 8'h18 &&
      $past(reg_addr, 2) <= 8'h1b) else $error("request fell uncleared");
endmodule : rsi_irq_chk

bind rsi_regulator_irq rsi_irq_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
   .otp_reset_irq_block(otp_reset_irq_block),
   .linreg_a_enabled_flag(linreg_a_enabled_flag),
   .linreg_a_output_invalid_raw(linreg_a_output_invalid_raw),
   .linreg_a_current_limit_raw(linreg_a_current_limit_raw),
   .linreg_b_enabled_flag(linreg_b_enabled_flag),
   .linreg_b_output_invalid_raw(linreg_b_output_invalid_raw),
   .linreg_b_current_limit_raw(linreg_b_current_limit_raw));

// file: tb/tb_regulator_status_and_irq_masks.sv
// Self-checking bench for the regulator status and interrupt mask slice.
// Assumes rsi_host_model on the register port and the bound checker.
module tb_regulator_status_and_irq_masks;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic otp = 1'b1;
   logic [16:0] ev = '0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, irq;
   int failures = 0;
   int num_checks = 0;

   always #2.5 mclk = ~mclk;

   rsi_host_model u_host (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
      .reg_rdata);
   rsi_regulator_irq dut (.mclk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
      .reg_rd, .reg_rdata, .irq, .otp_reset_irq_block(otp),
      .power_good_pin_state(ev[0]), .sync_clk_invalid(ev[1]),
      .thermal_warning_state(ev[2]), .current_measure_ready(ev[3]),
      .register_reset_event(ev[4]), .switcher_a_enabled(ev[5]),
      .switcher_a_output_invalid(ev[6]), .switcher_a_current_limit(ev[7]),
      .switcher_b_enabled(ev[8]), .switcher_b_output_invalid(ev[9]),
      .switcher_b_current_limit(ev[10]), .linreg_a_enabled_flag(ev[11]),
      .linreg_a_output_invalid_raw(ev[12]),
      .linreg_a_current_limit_raw(ev[13]), .linreg_b_enabled_flag(ev[14]),
      .linreg_b_output_invalid_raw(ev[15]),
      .linreg_b_current_limit_raw(ev[16]));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(a, d);
      check(d, exp);
   endtask : rdc

   // Request shows four edges after the raw change; six leaves margin
   task automatic fire(input int i, input logic lvl, input logic exp,
      input logic [7:0] fa, input logic [7:0] fb);
      @(negedge mclk);
      ev[i] = lvl;
      repeat (6) @(negedge mclk);
      check({7'h0, irq}, {7'h0, exp});
      if (exp)
      begin
         rdc(fa, fb);
         u_host.wr(fa, fb);
         repeat (2) @(negedge mclk);
         check({7'h0, irq}, 8'h00);
      end
   endtask : fire

   task automatic do_reset;
      @(negedge mclk);
      sys_rst = 1'b1;
      repeat (5) @(negedge mclk);
      sys_rst = 1'b0;
   endtask : do_reset

   task automatic summarize;
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_defaults;
      rdc(8'h20, 8'h90);
      rdc(8'h21, 8'h01);
      rdc(8'h22, 8'hcc);
      rdc(8'h1f, 8'h00);
      rdc(8'h30, 8'h00);
   endtask : t_defaults

   task automatic t_mask_rw;
      u_host.wr(8'h20, 8'hff);
      rdc(8'h20, 8'h95);
      u_host.wr(8'h21, 8'hfe);
      rdc(8'h21, 8'h01);
      u_host.wr(8'h22, 8'hff);
      rdc(8'h22, 8'hdd);
      u_host.wr(8'h1f, 8'hff);
      rdc(8'h1f, 8'h00);
      u_host.wr(8'h20, 8'h00);
      rdc(8'h20, 8'h00);
   endtask : t_mask_rw

   task automatic t_status;
      int idx [6] = '{11, 12, 13, 14, 15, 16};
      int pos [6] = '{3, 2, 0, 7, 6, 4};
      logic [7:0] exp;
      u_host.wr(8'h23, 8'hff);
      exp = 8'h00;
      foreach (idx[k])
      begin
         @(negedge mclk);
         ev[idx[k]] = 1'b1;
         exp[pos[k]] = 1'b1;
         repeat (3) @(negedge mclk);
         rdc(8'h1f, exp);
      end
      @(negedge mclk);
      ev = '0;
      repeat (3) @(negedge mclk);
      rdc(8'h1f, 8'h00);
      check({7'h0, irq}, 8'h00);
   endtask : t_status

   task automatic t_events;
      fire(0, 1'b1, 1'b1, 8'h18, 8'h80);
      fire(1, 1'b1, 1'b1, 8'h18, 8'h10);
      fire(2, 1'b1, 1'b1, 8'h18, 8'h04);
      fire(3, 1'b1, 1'b1, 8'h18, 8'h01);
      u_host.wr(8'h20, 8'h95);
      fire(0, 1'b0, 1'b0, 8'h00, 8'h00);
      fire(1, 1'b0, 1'b0, 8'h00, 8'h00);
      fire(2, 1'b0, 1'b0, 8'h00, 8'h00);
      fire(2, 1'b1, 1'b0, 8'h00, 8'h00);
      fire(3, 1'b0, 1'b0, 8'h00, 8'h00);
      fire(3, 1'b1, 1'b0, 8'h00, 8'h00);
      rdc(8'h18, 8'h00);
      u_host.wr(8'h23, 8'h08);
      fire(12, 1'b1, 1'b0, 8'h00, 8'h00);
      fire(12, 1'b0, 1'b1, 8'h1b, 8'h04);
      u_host.wr(8'h22, 8'hcc);
      fire(10, 1'b1, 1'b1, 8'h1a, 8'h10);
      u_host.wr(8'h22, 8'hdc);
      fire(10, 1'b0, 1'b0, 8'h00, 8'h00);
      fire(10, 1'b1, 1'b0, 8'h00, 8'h00);
      fire(4, 1'b1, 1'b0, 8'h00, 8'h00);
      u_host.wr(8'h22, 8'h08);
      fire(6, 1'b1, 1'b0, 8'h00, 8'h00);
      fire(6, 1'b0, 1'b1, 8'h1a, 8'h04);
      u_host.wr(8'h23, 8'h80);
      fire(15, 1'b1, 1'b0, 8'h00, 8'h00);
      fire(15, 1'b0, 1'b1, 8'h1b, 8'h40);
      fire(16, 1'b1, 1'b1, 8'h1b, 8'h10);
   endtask : t_events

   task automatic t_otp_mask;
      @(negedge mclk);
      ev = '0;
      otp = 1'b0;
      do_reset();
      repeat (3) @(negedge mclk);
      rdc(8'h21, 8'h00);
      rdc(8'h20, 8'h90);
      fire(4, 1'b1, 1'b1, 8'h19, 8'h01);
   endtask : t_otp_mask

   initial
   begin
      do_reset();
      t_defaults();
      t_mask_rw();
      t_status();
      t_events();
      t_otp_mask();
      summarize();
   end

   initial
   begin
      #100us;
      failures++;
      summarize();
   end
endmodule : tb_regulator_status_and_irq_masks
